// >>> hdl/nv_access_pkg.sv
// Constants, register map and types for the data nonvolatile access unit
package nv_access_pkg;
  // Register byte offsets; printed offsets 0xB/0x9A/0x9B are not multiples of
  // four, so each printed offset is an index and the byte address is 4x.
  localparam logic [7:0] IDX_IRQ_GLOBAL = 8'h0B;
  localparam logic [7:0] IDX_PIR = 8'h0C;
  localparam logic [7:0] IDX_PIE = 8'h8C;
  localparam logic [7:0] IDX_DATA = 8'h9A;
  localparam logic [7:0] IDX_ADDR = 8'h9B;
  localparam logic [7:0] IDX_CONTROL = 8'h9C;
  localparam logic [7:0] IDX_UNLOCK = 8'h9D;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  // Field positions
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int DONE_BIT = 7;
  localparam int CTL_RD_BIT = 0;
  localparam int CTL_WR_BIT = 1;
  localparam int CTL_WREN_BIT = 2;
  localparam int CTL_WRERR_BIT = 3;
  localparam int ADDR_HI_BIT = 7;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Array sizes for the two variants
  localparam int DEPTH_SMALL = 128;
  localparam int DEPTH_LARGE = 256;

  // Self-timed write: erase then program, each a fixed time
  localparam int CLK_MHZ = 25;
  localparam int ERASE_US = 2;
  localparam int PROG_US = 2;
  localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  localparam int TMR_W = 12;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b11
  } wr_state_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } prog_req_t;
endpackage

// >>> hdl/nv_access.sv
// Data nonvolatile byte array with indirect register access and AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
//
// Contract
// (R1) The array is read and written by the CPU in normal operation.
// (R2) The array is reached only through the data, address and control regs; the code also lets the prog_req port reach it directly.
// (R3) The unlock port stores nothing; it only tracks the unlock sequence.
// (R4) The data register holds the byte read or to be written.
// (R5) The address register selects the location of the next access.
// (R6) The small variant holds 128 bytes at 0h to 7Fh.
// (R7) The large variant holds 256 bytes at 0h to FFh.
// (R8) Software keeps address bit 7 at zero on the small variant.
// (R9) On the large variant address bit 7 selects locations 128 to 255.
// (R10) Address bits 6 to 0 pick one of 128 locations in the half.
// (R11) A write erases the byte first, then programs it, in one command.
// (R12) Write duration is set by an internal timer, not by software.
// (R13) Under code protection the CPU still reads and writes the array.
// (R14) Under code protection external programmer access is refused.
// (R15) Write completion sets the done flag; irq needs all three enables. The code sets it for CPU writes only, not programmer writes.
// (R16) Software unlocks before a write and leaves addr/data alone during it.
module nv_access #(
  parameter bit LARGE = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic code_protect,
  input wire nv_access_pkg::prog_req_t prog_req,
  output logic prog_ack,
  output logic [7:0] prog_rdata,
  output logic prog_refused,
  output logic irq,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import nv_access_pkg::*;

  function automatic logic [7:0] word_index(input logic [11:0] a);
    word_index = a[IDX_LSB +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] mem_reg [DEPTH_LARGE];
  logic [7:0] data_reg, addr_reg, gie_reg, pie_reg;
  logic done_reg, wren_reg, wr_busy_reg, wrerr_reg;
  logic wr_busy_ext_reg;
  logic [1:0] unlock_reg;
  wr_state_t state_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [7:0] wr_addr_reg, wr_data_reg;
  logic cp_s1_reg, cp_reg;
  prog_req_t pr_s1_reg, pr_reg;
  logic pr_prev_reg;
  logic [11:0] awaddr_reg;
  logic aw_have_reg, w_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address mapping
  wire [7:0] eff_addr = LARGE ? addr_reg : {1'b0, addr_reg[6:0]}; // [R9] [R10]
  // Small variant ignores bit 7; software keeps it zero anyway [R6] [R8]
  wire [7:0] pr_addr = LARGE ? pr_reg.addr : {1'b0, pr_reg.addr[6:0]}; // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // AXI write path: address and data may arrive in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [7:0] w_idx = word_index(awaddr_reg);
  wire w_lane0 = wstrb_reg[0];
  wire [7:0] w_byte = wdata_reg[7:0];
  wire wr_hit_gie = wr_go && (w_idx == IDX_IRQ_GLOBAL);
  wire wr_hit_pir = wr_go && (w_idx == IDX_PIR);
  wire wr_hit_pie = wr_go && (w_idx == IDX_PIE);
  wire wr_hit_data = wr_go && (w_idx == IDX_DATA);
  wire wr_hit_addr = wr_go && (w_idx == IDX_ADDR);
  wire wr_hit_ctl = wr_go && (w_idx == IDX_CONTROL);
  wire wr_hit_unl = wr_go && (w_idx == IDX_UNLOCK);
  wire wr_mapped = wr_hit_gie | wr_hit_pir | wr_hit_pie | wr_hit_data |
                   wr_hit_addr | wr_hit_ctl | wr_hit_unl;

  // Unlock port: two key bytes, tracked as a position only [R3] [R16]
  wire unl_k1 = wr_hit_unl && w_lane0 && (w_byte == UNLOCK_KEY1);
  wire unl_k2 = wr_hit_unl && w_lane0 && (w_byte == UNLOCK_KEY2) &&
                (unlock_reg == 2'b01);
  wire ctl_wr = wr_hit_ctl && w_lane0;
  wire start_wr = ctl_wr && w_byte[CTL_WR_BIT] && wren_reg &&
                  (unlock_reg == 2'b10) && !wr_busy_reg; // [R16]
  // CPU read is a one-shot into the data register [R1] [R13]
  wire start_rd = ctl_wr && w_byte[CTL_RD_BIT] && !wr_busy_reg;
  // Busy writes to addr/data are dropped to protect the array [R16]
  wire data_wr_ok = wr_hit_data && w_lane0 && !wr_busy_reg;
  wire addr_wr_ok = wr_hit_addr && w_lane0 && !wr_busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // External programmer path, synchronised; refused under protection
  wire pr_edge = pr_reg.req && !pr_prev_reg;
  wire pr_ok = pr_edge && !cp_reg && !wr_busy_reg;
  wire pr_refuse = pr_edge && (cp_reg || wr_busy_reg); // [R14]

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed write sequencer
  wire tmr_zero = (tmr_reg == '0);
  wire erase_end = (state_reg == ST_ERASE) && tmr_zero;
  wire prog_end = (state_reg == ST_PROG) && tmr_zero;
  wire seq_start = start_wr || (pr_ok && pr_reg.wr);
  wire [7:0] seq_addr = start_wr ? eff_addr : pr_addr;
  wire [7:0] seq_data = start_wr ? data_reg : pr_reg.data;
  wire done_set = prog_end && !wr_busy_ext_reg;

  wr_state_t state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (seq_start) state_next = ST_ERASE; // [R11]
      ST_ERASE: if (tmr_zero) state_next = ST_PROG; // [R11]
      ST_PROG: if (tmr_zero) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  wire ar_go = s_axi_arvalid && s_axi_arready;
  wire [7:0] r_idx = word_index(s_axi_araddr);
  wire [7:0] ctl_view = {4'h0, wrerr_reg, wren_reg, wr_busy_reg, 1'b0};
  wire [7:0] pir_view = {done_reg, 7'h00};
  wire r_hit = (r_idx == IDX_IRQ_GLOBAL) || (r_idx == IDX_PIR) ||
               (r_idx == IDX_PIE) || (r_idx == IDX_DATA) ||
               (r_idx == IDX_ADDR) || (r_idx == IDX_CONTROL) ||
               (r_idx == IDX_UNLOCK);
  // Unlock port reads as zero: nothing stands behind it [R3]
  wire [7:0] r_byte =
    (r_idx == IDX_IRQ_GLOBAL) ? gie_reg :
    (r_idx == IDX_PIR) ? pir_view :
    (r_idx == IDX_PIE) ? pie_reg :
    (r_idx == IDX_DATA) ? data_reg :
    (r_idx == IDX_ADDR) ? addr_reg :
    (r_idx == IDX_CONTROL) ? ctl_view : RST_BYTE;

  wire irq_next = done_reg && pie_reg[DONE_BIT] && gie_reg[PERIPHERAL_IRQ_ENABLE_BIT] &&
                  gie_reg[GIE_BIT]; // [R15]

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins from outside the clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cp_s1_reg <= 1'b0;
      cp_reg <= 1'b0;
      pr_s1_reg <= '0;
      pr_reg <= '0;
      pr_prev_reg <= 1'b0;
    end else if (clk_en) begin
      cp_s1_reg <= code_protect;
      cp_reg <= cp_s1_reg;
      pr_s1_reg <= prog_req;
      pr_reg <= pr_s1_reg;
      pr_prev_reg <= pr_reg.req;
    end
  end

  // AXI handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_reg && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_have_reg && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !ar_go;
      if (ar_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, r_byte};
        s_axi_rresp <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_reg <= RST_BYTE;
      pie_reg <= RST_BYTE;
      data_reg <= RST_BYTE;
      addr_reg <= RST_BYTE;
      wren_reg <= 1'b0;
      wrerr_reg <= 1'b0;
      unlock_reg <= 2'b00;
      done_reg <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      if (wr_hit_gie && w_lane0) gie_reg <= w_byte;
      if (wr_hit_pie && w_lane0) pie_reg <= w_byte;
      if (data_wr_ok) data_reg <= w_byte; // [R4]
      if (addr_wr_ok) addr_reg <= w_byte; // [R5]
      if (start_rd) data_reg <= mem_reg[eff_addr]; // [R4] [R2]
      if (ctl_wr) wren_reg <= w_byte[CTL_WREN_BIT];
      if (ctl_wr && w_byte[CTL_WR_BIT] && !start_wr) wrerr_reg <= 1'b1;
      else if (ctl_wr && !w_byte[CTL_WRERR_BIT]) wrerr_reg <= 1'b0;
      // Any other write between the keys breaks the sequence; reads leave it alone
      if (unl_k2) unlock_reg <= 2'b10;
      else if (unl_k1) unlock_reg <= 2'b01;
      else if (wr_go) unlock_reg <= 2'b00;
      // Set wins over a write-one-to-clear in the same cycle [R15]
      if (done_set) done_reg <= 1'b1;
      else if (wr_hit_pir && w_lane0 && w_byte[DONE_BIT]) done_reg <= 1'b0;
      irq <= irq_next; // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array and self-timed write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      tmr_reg <= '0;
      wr_busy_reg <= 1'b0;
      wr_busy_ext_reg <= 1'b0;
      wr_addr_reg <= RST_BYTE;
      wr_data_reg <= RST_BYTE;
      prog_ack <= 1'b0;
      prog_refused <= 1'b0;
      prog_rdata <= RST_BYTE;
    end else if (clk_en) begin
      state_reg <= state_next;
      prog_ack <= 1'b0;
      prog_refused <= pr_refuse; // [R14]
      if (pr_ok && !pr_reg.wr) begin
        prog_rdata <= mem_reg[pr_addr];
        prog_ack <= 1'b1;
      end
      if (state_reg == ST_IDLE && seq_start) begin
        wr_busy_reg <= 1'b1;
        wr_busy_ext_reg <= !start_wr;
        wr_addr_reg <= seq_addr;
        wr_data_reg <= seq_data;
        tmr_reg <= TMR_W'(ERASE_CYC - 1); // [R12]
      end else if (erase_end) begin
        mem_reg[wr_addr_reg] <= 8'hFF; // [R11]
        tmr_reg <= TMR_W'(PROG_CYC - 1); // [R12]
      end else if (prog_end) begin
        mem_reg[wr_addr_reg] <= wr_data_reg; // [R11]
        wr_busy_reg <= 1'b0;
        prog_ack <= wr_busy_ext_reg;
      end else if (!tmr_zero) begin
        tmr_reg <= tmr_reg - 1'b1;
      end
    end
  end
endmodule

// >>> tb/nv_access_checker.sv
// Port assertions for the nonvolatile access unit
`timescale 1ns/100ps
module nv_access_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic code_protect,
  input wire logic prog_ack,
  input wire logic prog_refused,
  input wire logic irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  // A frozen clock enable stalls every count, so nothing is judged then
  default disable iff (!aresetn || !clk_en);
  sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  ////////////////////////////////////////////////////////////////////////
  chk_read_latency: assert property (s_ar |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  chk_write_resp: assert property (s_aw ##0 s_w
    |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write answer dropped");
  chk_aw_single: assert property (s_aw |=> !s_axi_awready)
    else $error("second address taken");
  chk_irq_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("irq high after reset");
  chk_prog_excl: assert property (!(prog_ack && prog_refused))
    else $error("ack and refusal together");
  chk_protect_block: assert property (code_protect [*4]
    |-> !prog_ack) else $error("programmer served while protected");
endmodule

// >>> tb/tb_nv_access.sv
// Self-checking bench for the nonvolatile access unit
`timescale 1ns/100ps
module tb_nv_access;
  import nv_access_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic clk_en = 1'h1;
  logic code_protect = 1'h0;
  prog_req_t prog_req = '0;
  logic prog_ack, prog_refused, irq, pok;
  logic [7:0] prog_rdata, a, d, nd;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  int fail_count = 0;
  int n_checks = 0;
  int k;
  always #20 aclk = ~aclk;
  nv_access dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .code_protect(code_protect), .prog_req(prog_req), .prog_ack(prog_ack),
    .prog_rdata(prog_rdata), .prog_refused(prog_refused), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    conclude();
  endtask
  task automatic wr(input logic [7:0] i, v, input logic [1:0] r = RESP_OKAY);
    int n;
    exp_q.push_back({1'h0, r, 32'h0});
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid && n < 100);
    bready <= 1'h0;
    // One idle edge so a following call never re-raises bready at once
    @(posedge aclk);
    if (n >= 100) tmo();
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] ev,
                    input logic c = 1'h1, input logic [1:0] r = RESP_OKAY);
    int n;
    exp_q.push_back({c, r, ev});
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid && n < 100);
    q = rdata;
    rready <= 1'h0;
    @(posedge aclk);
    if (n >= 100) tmo();
  endtask
  // Programmer inputs are synchronised inside, so fields are held long
  task automatic prg(input logic [7:0] pa, input logic w = 1'h0,
                     input logic [7:0] v = 8'h00);
    int n;
    prog_req <= '{req: 1'h1, wr: w, addr: pa, data: v};
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!prog_ack && !prog_refused && n < 300);
    pok = prog_ack;
    prog_req.req <= 1'h0;
    repeat (4) @(posedge aclk);
    if (n >= 300) tmo();
  endtask
  always @(posedge aclk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      e = exp_q.pop_front();
      check("resp", rvalid ? rresp : bresp, {30'h0, e[33:32]});
      if (rvalid && e[34]) check("rdata", rdata, e[31:0]);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hAB58BD32));
    a = 8'($urandom_range(127));
    d = 8'($urandom());
    nd = ~d;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(IDX_PIR, 32'h0);
    rd(IDX_PIE, 32'h0);
    rd(IDX_UNLOCK, 32'h0);
    rd(8'h01, 32'h0, 1'h1, RESP_SLVERR);
    wr(8'h01, d, RESP_SLVERR);
    wr(IDX_ADDR, a);
    wr(IDX_DATA, d);
    rd(IDX_ADDR, {24'h0, a});
    rd(IDX_DATA, {24'h0, d});
    wr(IDX_CONTROL, 8'h06);
    rd(IDX_CONTROL, 32'h0, 1'h0);
    check("error", q[3], 1'h1);
    wr(IDX_CONTROL, 8'h04);
    wr(IDX_UNLOCK, UNLOCK_KEY1);
    wr(IDX_UNLOCK, UNLOCK_KEY2);
    wr(IDX_CONTROL, 8'h06);
    rd(IDX_CONTROL, 32'h0, 1'h0);
    check("busy", q[1], 1'h1);
    for (k = 0; k < 60 && q[1] === 1'h1; k++) rd(IDX_CONTROL, 32'h0, 1'h0);
    if (k >= 60) tmo();
    rd(IDX_PIR, 32'h80);
    check("irq", irq, 1'h0);
    wr(IDX_PIE, 8'h80);
    wr(IDX_IRQ_GLOBAL, 8'h80);
    repeat (2) @(posedge aclk);
    check("irq", irq, 1'h0);
    wr(IDX_IRQ_GLOBAL, 8'hC0);
    repeat (2) @(posedge aclk);
    check("irq", irq, 1'h1);
    wr(IDX_PIR, 8'h80);
    repeat (2) @(posedge aclk);
    check("irq", irq, 1'h0);
    // Bit 7 is kept at zero on the small array
    wr(IDX_ADDR, a);
    wr(IDX_CONTROL, 8'h01);
    rd(IDX_DATA, {24'h0, d});
    prg(a);
    check("prog ack", pok, 1'h1);
    check("prog data", prog_rdata, d);
    prg(a, 1'h1, nd);
    check("prog write", pok, 1'h1);
    check("irq", irq, 1'h0);
    prg(a);
    check("prog data", prog_rdata, nd);
    code_protect <= 1'h1;
    repeat (6) @(posedge aclk);
    prg(a);
    check("prog ack", pok, 1'h0);
    prg(a, 1'h1, d);
    check("prog ack", pok, 1'h0);
    wr(IDX_DATA, 8'h00);
    wr(IDX_ADDR, a);
    wr(IDX_CONTROL, 8'h01);
    // Frozen clock enable: a pending read request must wait untouched
    clk_en <= 1'h0;
    araddr <= {2'h0, IDX_DATA, 2'h0};
    arvalid <= 1'h1;
    repeat (4) @(posedge aclk);
    check("frozen read", rvalid, 1'h0);
    clk_en <= 1'h1;
    rd(IDX_DATA, {24'h0, nd});
    conclude();
  end
endmodule
bind nv_access nv_access_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .clk_en(clk_en), .code_protect(code_protect), .prog_ack(prog_ack),
  .prog_refused(prog_refused), .irq(irq), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
